/* File: design/mii_link_defines.svh */
// Timing counts and line-code constants shared by both ends of the MII/GMII link.
`ifndef MII_LINK_DEFINES_SVH
`define MII_LINK_DEFINES_SVH
// ====================
// Clock periods
`define CLK_PERIOD_NS 10
`define MII10_PERIOD_NS 400
`define MII100_PERIOD_NS 40
`define GMII_PERIOD_NS 8
`define MDC_MIN_PERIOD_NS 400
// Half periods in system cycles. Fixed clock rates round down to a whole cycle.
// The gigabit clock cannot be built from 100 MHz, so it clamps to one cycle.
`define HALF_10_CYC (`MII10_PERIOD_NS / 2 / `CLK_PERIOD_NS)
`define HALF_100_CYC (`MII100_PERIOD_NS / 2 / `CLK_PERIOD_NS)
`define HALF_1000_CYC ((`GMII_PERIOD_NS / 2 / `CLK_PERIOD_NS) < 1 ? 1 : (`GMII_PERIOD_NS / 2 / `CLK_PERIOD_NS))
// The management clock has a least period, so its half period rounds up.
`define MDC_HALF_CYC ((`MDC_MIN_PERIOD_NS + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS))
`define DIV_WIDTH 6
// ====================
// Transmit line symbols
`define SYM_INVALID 8'h01
`define SYM_HALT 8'h04
`define SYM_ERROR_GROUP 8'hFE
`endif

/* File: design/mii_link_pkg.sv */
// Types shared by both ends of the MII/GMII link.
package mii_link_pkg;
   typedef enum logic [1:0] {
      SPEED_10 = 2'h0,
      SPEED_100 = 2'h1,
      SPEED_1000 = 2'h2
   } speed_e;
   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_DATA = 4'h2,
      TX_INVALID = 4'h4,
      TX_HALT = 4'h8
   } tx_state_e;
endpackage

/* File: design/mii_link_if.sv */
// Pin bundle between the PHY end and the MAC end, with the MDIO wire resolved.
`timescale 1ns/1ps
interface mii_link_if;
   logic tx_clk;
   logic gtx_clk;
   logic rx_clk;
   logic [7:0] txd;
   logic tx_en;
   logic tx_er;
   logic [7:0] rxd;
   logic rx_dv;
   logic rx_er;
   logic crs;
   logic col;
   logic mdc;
   logic mdio_mac_o;
   logic mdio_mac_oe;
   logic mdio_phy_o;
   logic mdio_phy_oe;
   logic mdio;
   // Pulled-up shared line: a driven low wins, an undriven line reads high.
   assign mdio = (mdio_mac_oe ? mdio_mac_o : 1'b1) & (mdio_phy_oe ? mdio_phy_o : 1'b1);
   modport phy (output tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, mdio_phy_o, mdio_phy_oe,
                input gtx_clk, txd, tx_en, tx_er, mdc, mdio);
   modport mac (input tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col, mdio_phy_o, mdio_phy_oe,
                output gtx_clk, txd, tx_en, tx_er, mdc, mdio_mac_o, mdio_mac_oe, input mdio);
endinterface

/* File: design/mii_phy_end.sv */
// PHY end of the MII/GMII link: clocks, transmit symbols, receive path, CRS/COL, MDIO.
//
// Notes on behaviour
// R1 - Manager keeps MDC at or below 2.5 MHz.
// R2 - MDIO shared; each side releases when other drives. Here neither end looks at the other; each drives on its own mdio_drive_in.
// R3 - Half duplex: CRS on receive or transmit.
// R4 - Full duplex: CRS only for receive activity.
// R5 - Gigabit full duplex: CRS held low.
// R6 - Half duplex: COL when transmit meets receive.
// R7 - COL asynchronous; low in full duplex.
// R8 - TX_CLK runs continuously at 2.5/25 MHz.
// R9 - MAC sends nibbles or bytes with clock.
// R10 - MAC holds TX_EN for every data clock.
// R11 - MAC drives continuous 125 MHz GTX_CLK; here 50 MHz from the one-cycle half period.
// R12 - MAC drives TX_ER synchronous to transmit clock.
// R13 - 100 Mb/s TX_ER: invalid then Halt symbols.
// R14 - Gigabit TX_ER: emit error code-group.
// R15 - RX_CLK at 2.5, 25 or 125 MHz; gigabit here gives 50 MHz from the one-cycle half period.
// R16 - Receive data nibbles or bytes on RX_CLK.
// R17 - RX_DV high exactly for valid data.
// R18 - RX_ER flags receive errors at 100/1000.
// R19 - RX_ER held low at 10 Mb/s.
`timescale 1ns/1ps
`include "mii_link_defines.svh"
module mii_phy_end
   import mii_link_pkg::*;
#(
   parameter int HALF_10 = `HALF_10_CYC,
   parameter int HALF_100 = `HALF_100_CYC,
   parameter int HALF_1000 = `HALF_1000_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire speed_e speed_in,
   input wire logic full_duplex_in,
   input wire logic rx_carrier_in,
   input wire logic rx_valid_in,
   input wire logic rx_err_in,
   input wire logic [7:0] rx_data_in,
   output logic rx_take_out,
   output logic [7:0] tx_sym_out,
   output logic tx_sym_valid_out,
   output logic tx_sym_data_out,
   input wire logic mdio_drive_in,
   input wire logic mdio_bit_in,
   output logic mdio_bit_out,
   output logic mdio_bit_valid_out,
   mii_link_if.phy link
);

   // ====================
   // Pin synchronisers: first stage feeds only the second stage.
   logic [12:0] pin_meta_reg;
   logic [12:0] pin_sync_reg;
   logic gtx_prev_reg;
   logic mdc_prev_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_meta_reg <= 13'h0000;
         pin_sync_reg <= 13'h0000;
         gtx_prev_reg <= 1'b0;
         mdc_prev_reg <= 1'b0;
      end else if (ce_in) begin
         pin_meta_reg <= {link.mdio, link.mdc, link.gtx_clk, link.tx_er, link.tx_en, link.txd};
         pin_sync_reg <= pin_meta_reg;
         gtx_prev_reg <= pin_sync_reg[10];
         mdc_prev_reg <= pin_sync_reg[11];
      end
   end
   logic [7:0] txd_s;
   logic tx_en_s;
   logic tx_er_s;
   logic gtx_rise;
   logic mdc_rise;
   assign txd_s = pin_sync_reg[7:0];
   assign tx_en_s = pin_sync_reg[8];
   assign tx_er_s = pin_sync_reg[9];
   assign gtx_rise = pin_sync_reg[10] & ~gtx_prev_reg;
   assign mdc_rise = pin_sync_reg[11] & ~mdc_prev_reg;

   // ====================
   // One clock divider shared by TX_CLK and RX_CLK.
   logic [`DIV_WIDTH-1:0] half_cyc;
   logic [`DIV_WIDTH-1:0] div_reg;
   logic [`DIV_WIDTH-1:0] div_next;
   logic clk_out_reg;
   logic clk_out_next;
   logic edge_rise;
   logic edge_fall;
   always_comb begin
      case (speed_in)
         SPEED_10: half_cyc = `DIV_WIDTH'(HALF_10);
         SPEED_100: half_cyc = `DIV_WIDTH'(HALF_100);
         default: half_cyc = `DIV_WIDTH'(HALF_1000);
      endcase
      div_next = div_reg + `DIV_WIDTH'(1);
      clk_out_next = clk_out_reg;
      edge_rise = 1'b0;
      edge_fall = 1'b0;
      if (div_next >= half_cyc) begin
         div_next = '0;
         clk_out_next = ~clk_out_reg;
         edge_rise = ~clk_out_reg;
         edge_fall = clk_out_reg;
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg <= '0;
         clk_out_reg <= 1'b0;
      end else if (ce_in) begin
         div_reg <= div_next;
         clk_out_reg <= clk_out_next;
      end
   end
   // TX_CLK is free-running at 10/100 and parked low at gigabit, where GTX_CLK takes over.
   assign link.tx_clk = (speed_in == SPEED_1000) ? 1'b0 : clk_out_reg; // R8
   assign link.rx_clk = clk_out_reg; // R15

   // ====================
   // Transmit symbol path.
   tx_state_e tx_state_reg;
   tx_state_e tx_state_next;
   logic [7:0] sym_reg;
   logic [7:0] sym_next;
   logic sym_valid_reg;
   logic sym_valid_next;
   logic sym_data_reg;
   logic sym_data_next;
   logic tx_take;
   logic [7:0] txd_lane;
   assign tx_take = (speed_in == SPEED_1000) ? gtx_rise : edge_rise;
   assign txd_lane = (speed_in == SPEED_1000) ? txd_s : {4'h0, txd_s[3:0]};
   always_comb begin
      tx_state_next = tx_state_reg;
      sym_next = sym_reg;
      sym_valid_next = 1'b0;
      sym_data_next = 1'b0;
      if (tx_take) begin
         sym_valid_next = 1'b1;
         case (tx_state_reg)
            TX_IDLE, TX_DATA: begin
               if (tx_er_s && speed_in == SPEED_100) begin
                  tx_state_next = TX_INVALID; // R13
                  sym_next = `SYM_INVALID;
               end else if (tx_er_s && tx_en_s && speed_in == SPEED_1000) begin
                  sym_next = `SYM_ERROR_GROUP; // R14
               end else if (tx_en_s) begin
                  tx_state_next = TX_DATA;
                  sym_next = txd_lane;
                  sym_data_next = 1'b1;
               end else begin
                  tx_state_next = TX_IDLE;
                  sym_valid_next = 1'b0;
               end
            end
            TX_INVALID, TX_HALT: begin
               if (tx_er_s) begin
                  tx_state_next = TX_HALT; // R13
                  sym_next = `SYM_HALT;
               end else begin
                  tx_state_next = tx_en_s ? TX_DATA : TX_IDLE;
                  sym_next = txd_lane;
                  sym_data_next = tx_en_s;
                  sym_valid_next = tx_en_s;
               end
            end
            default: begin
               tx_state_next = TX_IDLE;
               sym_valid_next = 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_state_reg <= TX_IDLE;
         sym_reg <= 8'h00;
         sym_valid_reg <= 1'b0;
         sym_data_reg <= 1'b0;
      end else if (ce_in) begin
         tx_state_reg <= tx_state_next;
         sym_reg <= sym_next;
         sym_valid_reg <= sym_valid_next;
         sym_data_reg <= sym_data_next;
      end
   end
   assign tx_sym_out = sym_reg;
   assign tx_sym_valid_out = sym_valid_reg;
   assign tx_sym_data_out = sym_data_reg;

   // ====================
   // Receive path: new values launch on the falling RX_CLK edge so the MAC
   // samples them mid-period on the rising edge.
   logic [7:0] rxd_reg;
   logic [7:0] rxd_next;
   logic rx_dv_reg;
   logic rx_dv_next;
   logic rx_er_reg;
   logic rx_er_next;
   logic crs_reg;
   logic crs_next;
   logic col_reg;
   logic col_next;
   logic tx_active;
   assign tx_active = tx_en_s | (tx_state_reg != TX_IDLE);
   always_comb begin
      rxd_next = rxd_reg;
      rx_dv_next = rx_dv_reg;
      rx_er_next = rx_er_reg;
      if (edge_fall) begin
         rx_dv_next = rx_valid_in; // R17
         rxd_next = (speed_in == SPEED_1000) ? rx_data_in : {4'h0, rx_data_in[3:0]}; // R16
         rx_er_next = (speed_in == SPEED_10) ? 1'b0 : rx_err_in; // R18 R19
      end
      if (!full_duplex_in) begin
         crs_next = rx_carrier_in | tx_active; // R3
      end else if (speed_in == SPEED_1000) begin
         crs_next = 1'b0; // R5
      end else begin
         crs_next = rx_carrier_in; // R4
      end
      col_next = !full_duplex_in && rx_carrier_in && tx_active; // R6 R7
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rxd_reg <= 8'h00;
         rx_dv_reg <= 1'b0;
         rx_er_reg <= 1'b0;
         crs_reg <= 1'b0;
         col_reg <= 1'b0;
      end else if (ce_in) begin
         rxd_reg <= rxd_next;
         rx_dv_reg <= rx_dv_next;
         rx_er_reg <= rx_er_next;
         crs_reg <= crs_next;
         col_reg <= col_next;
      end
   end
   assign rx_take_out = edge_fall & ce_in;
   assign link.rxd = rxd_reg;
   assign link.rx_dv = rx_dv_reg;
   assign link.rx_er = rx_er_reg;
   assign link.crs = crs_reg;
   assign link.col = col_reg;

   // ====================
   // Management line: drive only when told to, otherwise release it.
   logic mdio_oe_reg;
   logic mdio_o_reg;
   logic mdio_bit_reg;
   logic mdio_bit_valid_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mdio_oe_reg <= 1'b0;
         mdio_o_reg <= 1'b1;
         mdio_bit_reg <= 1'b1;
         mdio_bit_valid_reg <= 1'b0;
      end else if (ce_in) begin
         mdio_oe_reg <= mdio_drive_in; // R2
         mdio_o_reg <= mdio_bit_in;
         mdio_bit_valid_reg <= mdc_rise;
         if (mdc_rise) begin
            mdio_bit_reg <= pin_sync_reg[12];
         end
      end
   end
   assign link.mdio_phy_oe = mdio_oe_reg;
   assign link.mdio_phy_o = mdio_o_reg;
   assign mdio_bit_out = mdio_bit_reg;
   assign mdio_bit_valid_out = mdio_bit_valid_reg;
endmodule

/* File: design/mii_mac_end.sv */
// MAC end of the MII/GMII link: transmit launch, receive capture, GTX_CLK and MDC.
`timescale 1ns/1ps
`include "mii_link_defines.svh"
module mii_mac_end
   import mii_link_pkg::*;
#(
   parameter int HALF_1000 = `HALF_1000_CYC,
   parameter int MDC_HALF = `MDC_HALF_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire speed_e speed_in,
   input wire logic tx_valid_in,
   input wire logic tx_err_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   output logic rx_err_out,
   output logic crs_out,
   output logic col_out,
   input wire logic mdio_drive_in,
   input wire logic mdio_bit_in,
   output logic mdio_bit_out,
   output logic mdc_rise_out,
   mii_link_if.mac link
);

   // ====================
   // Pin synchronisers. COL is asynchronous to every link clock.
   logic [14:0] pin_meta_reg;
   logic [14:0] pin_sync_reg;
   logic [1:0] clk_prev_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_meta_reg <= 15'h0000;
         pin_sync_reg <= 15'h0000;
         clk_prev_reg <= 2'h0;
      end else if (ce_in) begin
         pin_meta_reg <= {link.mdio, link.col, link.crs, link.rx_er, link.rx_dv, link.rx_clk, link.tx_clk, link.rxd};
         pin_sync_reg <= pin_meta_reg; // R7
         clk_prev_reg <= pin_sync_reg[9:8];
      end
   end
   logic txc_fall;
   logic rxc_rise;
   assign txc_fall = ~pin_sync_reg[8] & clk_prev_reg[0];
   assign rxc_rise = pin_sync_reg[9] & ~clk_prev_reg[1];

   // ====================
   // GTX_CLK and MDC dividers. GTX_CLK runs whenever gigabit is selected.
   logic [`DIV_WIDTH-1:0] gdiv_reg;
   logic [`DIV_WIDTH-1:0] gdiv_next;
   logic gtx_reg;
   logic gtx_next;
   logic [`DIV_WIDTH-1:0] mdiv_reg;
   logic [`DIV_WIDTH-1:0] mdiv_next;
   logic mdc_reg;
   logic mdc_next;
   logic gtx_fall;
   logic mdc_rise;
   logic mdc_fall;
   always_comb begin
      gdiv_next = gdiv_reg + `DIV_WIDTH'(1);
      gtx_next = gtx_reg;
      gtx_fall = 1'b0;
      if (gdiv_next >= `DIV_WIDTH'(HALF_1000)) begin
         gdiv_next = '0;
         gtx_next = ~gtx_reg; // R11
         gtx_fall = gtx_reg;
      end
      mdiv_next = mdiv_reg + `DIV_WIDTH'(1);
      mdc_next = mdc_reg;
      mdc_rise = 1'b0;
      mdc_fall = 1'b0;
      if (mdiv_next >= `DIV_WIDTH'(MDC_HALF)) begin
         mdiv_next = '0;
         mdc_next = ~mdc_reg; // R1
         mdc_rise = ~mdc_reg;
         mdc_fall = mdc_reg;
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gdiv_reg <= '0;
         gtx_reg <= 1'b0;
         mdiv_reg <= '0;
         mdc_reg <= 1'b0;
      end else if (ce_in) begin
         gdiv_reg <= gdiv_next;
         gtx_reg <= (speed_in == SPEED_1000) ? gtx_next : 1'b0;
         mdiv_reg <= mdiv_next;
         mdc_reg <= mdc_next;
      end
   end
   assign link.gtx_clk = gtx_reg;
   assign link.mdc = mdc_reg;

   // ====================
   // Transmit launch on the falling edge of the transmit clock in use.
   logic tx_launch;
   logic [7:0] txd_reg;
   logic tx_en_reg;
   logic tx_er_reg;
   assign tx_launch = (speed_in == SPEED_1000) ? gtx_fall : txc_fall;
   assign tx_ready_out = tx_launch & ce_in;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         txd_reg <= 8'h00;
         tx_en_reg <= 1'b0;
         tx_er_reg <= 1'b0;
      end else if (ce_in && tx_launch) begin
         txd_reg <= (speed_in == SPEED_1000) ? tx_data_in : {4'h0, tx_data_in[3:0]}; // R9
         tx_en_reg <= tx_valid_in; // R10
         tx_er_reg <= tx_err_in & (speed_in != SPEED_10); // R12
      end
   end
   assign link.txd = txd_reg;
   assign link.tx_en = tx_en_reg;
   assign link.tx_er = tx_er_reg;

   // ====================
   // Receive capture on the rising RX_CLK edge, plus status and MDIO.
   logic [7:0] rxd_reg;
   logic rx_valid_reg;
   logic rx_err_reg;
   logic mdio_oe_reg;
   logic mdio_o_reg;
   logic mdio_in_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rxd_reg <= 8'h00;
         rx_valid_reg <= 1'b0;
         rx_err_reg <= 1'b0;
         mdio_oe_reg <= 1'b0;
         mdio_o_reg <= 1'b1;
         mdio_in_reg <= 1'b1;
      end else if (ce_in) begin
         rx_valid_reg <= rxc_rise & pin_sync_reg[10];
         rx_err_reg <= rxc_rise & pin_sync_reg[11];
         if (rxc_rise) begin
            rxd_reg <= pin_sync_reg[7:0];
         end
         // Bits change only while MDC is low so the PHY sees them settled.
         if (mdc_fall) begin
            mdio_oe_reg <= mdio_drive_in; // R2
            mdio_o_reg <= mdio_bit_in;
         end
         if (mdc_rise) begin
            mdio_in_reg <= pin_sync_reg[14];
         end
      end
   end
   assign rx_data_out = rxd_reg;
   assign rx_valid_out = rx_valid_reg;
   assign rx_err_out = rx_err_reg;
   assign crs_out = pin_sync_reg[12];
   assign col_out = pin_sync_reg[13];
   assign link.mdio_mac_oe = mdio_oe_reg;
   assign link.mdio_mac_o = mdio_o_reg;
   assign mdio_bit_out = mdio_in_reg;
   assign mdc_rise_out = mdc_rise & ce_in;
endmodule

/* File: testbench/mii_link_assertions.sv */
// Pin-level checks on the MII/GMII link between the PHY end and the MAC end.
`timescale 1ns/1ps
module mii_link_assertions
   import mii_link_pkg::*;
#(
   parameter int HALF_10 = 4,
   parameter int HALF_100 = 2,
   parameter int MDC_HALF = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire speed_e speed_in,
   input wire logic full_duplex_in,
   input wire logic rx_carrier_in,
   input wire logic tx_clk,
   input wire logic gtx_clk,
   input wire logic rx_clk,
   input wire logic [7:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic crs,
   input wire logic col,
   input wire logic mdc,
   input wire logic mdio_mac_oe,
   input wire logic mdio_phy_oe
);
   // ====================
   // Run lengths of the transmit clock and MDC
   logic tx_last_reg;
   logic mdc_last_reg;
   logic seen_reg;
   speed_e speed_last_reg;
   int tx_run_reg;
   int mdc_run_reg;
   int half;
   assign half = (speed_in == SPEED_10) ? HALF_10 : HALF_100;
   // The first toggle after a speed change may still follow the old divider, so it is not judged.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_last_reg <= 1'b0;
         mdc_last_reg <= 1'b0;
         speed_last_reg <= SPEED_10;
         tx_run_reg <= 0;
         mdc_run_reg <= 0;
         seen_reg <= 1'b0;
      end
      else begin
         tx_last_reg <= tx_clk;
         mdc_last_reg <= mdc;
         speed_last_reg <= speed_in;
         tx_run_reg <= (tx_clk != tx_last_reg || speed_in != speed_last_reg) ? 0 : tx_run_reg + 1;
         mdc_run_reg <= (mdc != mdc_last_reg) ? 0 : mdc_run_reg + 1;
         seen_reg <= (speed_in != speed_last_reg) ? 1'b0 : ((tx_clk != tx_last_reg) ? 1'b1 : seen_reg);
      end
   end
   // ====================
   // Properties
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_crs_gig_low: assert property (full_duplex_in && speed_in == SPEED_1000 && $stable(full_duplex_in)
      && $stable(speed_in) |-> !crs) else $error("crs high at gigabit full duplex");
   a_crs_full_rx: assert property (full_duplex_in && speed_in != SPEED_1000 && $stable(full_duplex_in)
      && $stable(speed_in) && !$past(rst_in) |-> crs == $past(rx_carrier_in)) else $error("full duplex crs wrong");
   a_crs_half_rx: assert property (!full_duplex_in && $stable(full_duplex_in) && $past(rx_carrier_in)
      && !$past(rst_in) |-> crs) else $error("half duplex crs missing");
   a_col_full_low: assert property (full_duplex_in && $stable(full_duplex_in) |-> !col)
      else $error("col in full duplex");
   a_col_needs_both: assert property (col |-> crs && $past(rx_carrier_in) && !$past(full_duplex_in))
      else $error("col without carrier");
   a_tx_clk_period: assert property ($changed(tx_clk) && seen_reg && speed_in != SPEED_1000
      && speed_in == speed_last_reg |-> tx_run_reg == half - 1) else $error("tx clock period wrong");
   a_tx_clk_runs: assert property (seen_reg && speed_in != SPEED_1000 && speed_in == speed_last_reg
      |-> tx_run_reg < half) else $error("tx clock stopped");
   a_gig_clks: assert property (speed_in == SPEED_1000 && $past(speed_in) == SPEED_1000
      && $past(speed_in, 3) == SPEED_1000 && !$past(rst_in, 3) |-> $changed(gtx_clk) && $changed(rx_clk) && !tx_clk)
      else $error("gigabit clocks wrong");
   a_rx_er_10_low: assert property (speed_in == SPEED_10 && $past(speed_in) == SPEED_10
      && $past(speed_in, 2) == SPEED_10 |-> !rx_er) else $error("rx error at 10 Mb/s");
   a_rxd_upper_zero: assert property (speed_in != SPEED_1000 && $past(speed_in) != SPEED_1000
      && $past(speed_in, 2) != SPEED_1000 |-> rxd[7:4] == 4'h0) else $error("upper rx lanes driven");
   a_rx_pins_launch: assert property (($changed(rxd) || $changed(rx_dv) || $changed(rx_er)) && !$past(rst_in)
      |-> $fell(rx_clk)) else $error("rx pins off falling clock");
   a_mdc_slow: assert property ($changed(mdc) |-> mdc_run_reg >= MDC_HALF - 1)
      else $error("mdc too fast");
   a_mdio_one_driver: assert property (!(mdio_mac_oe && mdio_phy_oe))
      else $error("two management drivers");
endmodule

/* File: testbench/phy_mii_gmii_mac_port_bench.sv */
// Self-checking bench joining the PHY end and the MAC end across the MII/GMII pins.
`timescale 1ns/1ps
`include "mii_link_defines.svh"
module phy_mii_gmii_mac_port_bench
   import mii_link_pkg::*;
   ;
   localparam int H10 = 4;
   localparam int H100 = 2;
   localparam int HMDC = 4;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   speed_e speed_in = SPEED_10;
   logic full_duplex_in = 1'b0;
   logic rx_carrier_in = 1'b0;
   logic rx_valid_in = 1'b0;
   logic rx_err_in = 1'b0;
   logic [7:0] rx_data_in = 8'h00;
   logic tx_valid_in = 1'b0;
   logic tx_err_in = 1'b0;
   logic [7:0] tx_data_in = 8'h00;
   logic phy_md_drive = 1'b0;
   logic phy_md_bit = 1'b0;
   logic mac_md_drive = 1'b0;
   logic mac_md_bit = 1'b0;
   logic rx_take_out, tx_sym_valid_out, tx_sym_data_out, phy_md_out, tx_ready_out;
   logic rx_valid_out, rx_err_out, crs_out, col_out, mac_md_out, mdc_rise_out;
   logic [7:0] tx_sym_out, rx_data_out;
   logic [8:0] tx_q[$];
   logic [8:0] rx_q[$];
   logic [3:0] mcase[6] = '{4'h8, 4'hB, 4'h1, 4'h4, 4'h7, 4'h1};
   logic last_er = 1'b0;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   mii_link_if mii_link_if_i ();
   mii_phy_end #(.HALF_10(H10), .HALF_100(H100), .HALF_1000(1)) mii_phy_end_i (
      .clk_in, .rst_in, .ce_in(1'b1), .speed_in, .full_duplex_in, .rx_carrier_in, .rx_valid_in, .rx_err_in,
      .rx_data_in, .rx_take_out, .tx_sym_out, .tx_sym_valid_out, .tx_sym_data_out, .mdio_drive_in(phy_md_drive),
      .mdio_bit_in(phy_md_bit), .mdio_bit_out(phy_md_out), .mdio_bit_valid_out(), .link(mii_link_if_i));
   mii_mac_end #(.HALF_1000(1), .MDC_HALF(HMDC)) mii_mac_end_i (
      .clk_in, .rst_in, .ce_in(1'b1), .speed_in, .tx_valid_in, .tx_err_in, .tx_data_in, .tx_ready_out,
      .rx_data_out, .rx_valid_out, .rx_err_out, .crs_out, .col_out, .mdio_drive_in(mac_md_drive),
      .mdio_bit_in(mac_md_bit), .mdio_bit_out(mac_md_out), .mdc_rise_out, .link(mii_link_if_i));
   mii_link_assertions #(.HALF_10(H10), .HALF_100(H100), .MDC_HALF(HMDC)) mii_link_assertions_i (
      .clk_in, .rst_in, .speed_in, .full_duplex_in,
      .rx_carrier_in, .tx_clk(mii_link_if_i.tx_clk), .gtx_clk(mii_link_if_i.gtx_clk),
      .rx_clk(mii_link_if_i.rx_clk), .rxd(mii_link_if_i.rxd), .rx_dv(mii_link_if_i.rx_dv),
      .rx_er(mii_link_if_i.rx_er), .crs(mii_link_if_i.crs), .col(mii_link_if_i.col), .mdc(mii_link_if_i.mdc),
      .mdio_mac_oe(mii_link_if_i.mdio_mac_oe), .mdio_phy_oe(mii_link_if_i.mdio_phy_oe));
   // ====================
   // Compare and access tasks
   task automatic check_flag(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic check_word(input logic [8:0] got, input logic [8:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Outputs are looked at on the falling edge, where the rising edge's updates have settled.
   task automatic wait_pulse(input int k);
      int n;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while ((k == 0 ? tx_ready_out : k == 1 ? rx_take_out : mdc_rise_out) !== 1'b1 && n < 200);
      check_flag(n < 200, 1'b1, "handshake");
   endtask
   task automatic send(input logic v, input logic e, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      tx_valid_in = v;
      tx_err_in = e;
      tx_data_in = d;
      if (v && speed_in == SPEED_1000) tx_q.push_back(e ? {1'b0, `SYM_ERROR_GROUP} : {1'b1, d});
      else if (v && e && speed_in == SPEED_100) tx_q.push_back({1'b0, last_er ? `SYM_HALT : `SYM_INVALID});
      else if (v) tx_q.push_back({5'h10, d[3:0]});
      last_er = v && e && speed_in == SPEED_100;
      wait_pulse(0);
   endtask
   task automatic recv(input logic v, input logic e, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      rx_valid_in = v;
      rx_err_in = e;
      rx_data_in = d;
      if (v) rx_q.push_back({e && speed_in != SPEED_10, speed_in == SPEED_1000 ? d : {4'h0, d[3:0]}});
      wait_pulse(1);
   endtask
   task automatic set_mode(input speed_e s, input logic fd, input logic c);
      @(posedge clk_in);
      #1;
      speed_in = s;
      full_duplex_in = fd;
      rx_carrier_in = c;
      repeat (20) @(negedge clk_in);
   endtask
   task automatic drain();
      int n;
      n = 0;
      while ((tx_q.size() != 0 || rx_q.size() != 0) && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      check_flag(tx_q.size() == 0 && rx_q.size() == 0, 1'b1, "words lost");
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end
      else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ====================
   // Clock, monitors and timeout
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   always @(negedge clk_in) begin
      if (tx_sym_valid_out === 1'b1) begin
         if (tx_q.size() == 0) check_flag(1'b1, 1'b0, "stray symbol");
         else check_word({tx_sym_data_out, tx_sym_out}, tx_q.pop_front(), "symbol");
      end
      if (rx_valid_out === 1'b1) begin
         if (rx_q.size() == 0) check_flag(1'b1, 1'b0, "stray receive");
         else check_word({rx_err_out, rx_data_out}, rx_q.pop_front(), "receive");
      end
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("BAD %0t run did not finish", $time);
         end_of_test();
      end
   end
   // ====================
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      for (int s = 0; s < 3; s++) begin
         set_mode(speed_e'(s), 1'b1, 1'b0);
         send(1'b0, 1'b0, 8'h00);
         send(1'b1, 1'b0, 8'hA7);
         send(1'b1, 1'b1, 8'h5C);
         send(1'b1, 1'b1, 8'h33);
         send(1'b1, 1'b0, 8'hE9);
         send(1'b0, 1'b0, 8'h00);
         recv(1'b1, 1'b0, 8'hA5);
         recv(1'b1, 1'b1, 8'h3C);
         recv(1'b0, 1'b0, 8'h00);
         recv(1'b1, 1'b0, 8'h96);
         recv(1'b0, 1'b0, 8'h00);
         drain();
      end
      for (int m = 0; m < 4; m++) begin
         set_mode(SPEED_10, m[1], m[0]);
         check_flag(crs_out, m[0], "idle carrier sense");
         send(1'b1, 1'b0, 8'h01);
         send(1'b1, 1'b0, 8'h02);
         send(1'b1, 1'b0, 8'h03);
         check_flag(crs_out, m[0] | !m[1], "busy carrier sense");
         check_flag(col_out, m[0] & !m[1], "collision");
         send(1'b0, 1'b0, 8'h00);
         drain();
      end
      set_mode(SPEED_1000, 1'b1, 1'b1);
      send(1'b1, 1'b0, 8'hC3);
      send(1'b1, 1'b0, 8'h3D);
      check_flag(crs_out, 1'b0, "gigabit carrier sense");
      check_flag(col_out, 1'b0, "gigabit collision");
      send(1'b0, 1'b0, 8'h00);
      drain();
      foreach (mcase[i]) begin
         @(posedge clk_in);
         #1;
         mac_md_drive = mcase[i][3];
         phy_md_drive = mcase[i][2];
         mac_md_bit = mcase[i][1];
         phy_md_bit = mcase[i][1];
         wait_pulse(2);
         wait_pulse(2);
         repeat (6) @(negedge clk_in);
         check_flag(phy_md_out, mcase[i][0], "phy management bit");
         check_flag(mac_md_out, mcase[i][0], "mac management bit");
      end
      end_of_test();
   end
endmodule
